// >>> pkg/stopwatch_pkg.sv
// Shared constants, types and register map of the elapsed-time stopwatch
package stopwatch_pkg;

   // ****************************************************
   // Timing
   // ****************************************************
   localparam int CLK_KHZ = 25000;
   localparam int TICK_TIME_US = 10000;
   localparam int TICK_CYCLES = (TICK_TIME_US * CLK_KHZ) / 1000;
   localparam int TICKS_PER_SEC = 100;
   localparam int SECS_PER_MIN = 60;
   localparam int MINS_PER_HOUR = 60;
   localparam int VALUE_W = 32;

   // ****************************************************
   // Register map and fields
   // ****************************************************
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
   localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
   localparam logic [ADDR_W-1:0] ELAPSED_OFS = 8'h08;
   localparam logic [ADDR_W-1:0] RUNNING_OFS = 8'h0C;
   localparam logic [ADDR_W-1:0] HELD_OFS = 8'h10;
   localparam int CTRL_TB_LSB = 0;
   localparam int CTRL_RETAIN_BIT = 2;
   localparam int STATUS_RUN_BIT = 0;
   localparam int STATUS_LAP_BIT = 1;
   localparam int STATUS_ENABLE_BIT = 2;
   localparam int STATUS_CLEAR_BIT = 3;

   typedef enum logic [1:0] {
      TB_10MS,
      TB_SEC,
      TB_MIN,
      TB_HOUR
   } timebase_t;

   typedef struct packed {
      logic retain;
      timebase_t timebase_select;
   } ctrl_t;

   localparam ctrl_t CTRL_RESET = '{retain: 1'b0, timebase_select: TB_10MS};

   typedef struct packed {
      logic enable;
      logic lap;
      logic clear;
   } inputs_t;

endpackage

// >>> src/elapsed_time_stopwatch.sv
// Elapsed-time stopwatch with lap hold, selectable timebase and retention
//
// Contract
// - Enable starts accumulating and shows elapsed time
// - Lap rising edge pauses the stopwatch
// - Lap falling edge resumes the stopwatch
// - Clear input zeroes time and output
// - Count in 10 ms, s, min or h
// - Retain setting keeps count across power loss
// - Lap high holds output until lap low
// - Enable on, lap off: output running time
// - Enable on, lap on: capture held lap value
// - Enable off, lap on: stop, show held value
// - Enable off, lap off: output running time
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

module elapsed_time_stopwatch
   import stopwatch_pkg::*;
#(
   parameter int TICK_LEN = TICK_CYCLES,
   parameter int VAL_W = VALUE_W
)
(
   input wire logic CLOCK_I,
   input wire logic RST_I,
   input wire logic ENABLE_I,
   input wire logic LAP_I,
   input wire logic CLEAR_I,
   input wire logic POWER_LOSS_I,
   input wire logic [ADDR_W-1:0] ADDR_I,
   input wire logic [31:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [31:0] RDATA_O,
   output logic [VAL_W-1:0] ELAPSED_O,
   output logic RUNNING_O
);

   // ****************************************************
   // Input sampling and lap edges
   // ****************************************************
   inputs_t in_s;
   logic lap_prev_r;
   logic lap_rise;
   logic lap_fall;
   logic run_en;

   assign in_s = '{enable: ENABLE_I, lap: LAP_I, clear: CLEAR_I};

   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I)
         lap_prev_r <= 1'b0;
      else
         lap_prev_r <= in_s.lap;
   end

   assign lap_rise = in_s.lap & ~lap_prev_r;
   assign lap_fall = ~in_s.lap & lap_prev_r;

   assign run_en = in_s.enable & ~in_s.lap & ~in_s.clear;

   // ****************************************************
   // Control register
   // ****************************************************
   ctrl_t ctrl_r;

   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I)
         ctrl_r <= CTRL_RESET;
      else if (WR_I && ADDR_I == CTRL_OFS)
      begin
         ctrl_r.timebase_select <= timebase_t'(WDATA_I[CTRL_TB_LSB +: 2]);
         ctrl_r.retain <= WDATA_I[CTRL_RETAIN_BIT];
      end
   end

   // ****************************************************
   // Timebase prescaler
   // ****************************************************
   // The chain only advances while counting, so a pause keeps the partial
   // unit and the resumed count loses no fraction of the timebase.
   logic [$clog2(TICK_LEN)-1:0] tick_cnt_r;
   logic [6:0] csec_cnt_r;
   logic [5:0] sec_cnt_r;
   logic [5:0] min_cnt_r;
   logic tick_10ms;
   logic tick_sec;
   logic tick_min;
   logic tick_hour;
   logic step;
   logic prescale_clr;

   assign prescale_clr = in_s.clear | (POWER_LOSS_I & ~ctrl_r.retain);
   assign tick_10ms = run_en && (tick_cnt_r == ($clog2(TICK_LEN))'(TICK_LEN - 1));
   assign tick_sec = tick_10ms && (csec_cnt_r == 7'(TICKS_PER_SEC - 1));
   assign tick_min = tick_sec && (sec_cnt_r == 6'(SECS_PER_MIN - 1));
   assign tick_hour = tick_min && (min_cnt_r == 6'(MINS_PER_HOUR - 1));

   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I || prescale_clr)
         tick_cnt_r <= '0;
      else if (tick_10ms)
         tick_cnt_r <= '0;
      else if (run_en)
         tick_cnt_r <= tick_cnt_r + 1'b1;
   end

   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I || prescale_clr)
         csec_cnt_r <= '0;
      else if (tick_sec)
         csec_cnt_r <= '0;
      else if (tick_10ms)
         csec_cnt_r <= csec_cnt_r + 1'b1;
   end

   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I || prescale_clr)
         sec_cnt_r <= '0;
      else if (tick_min)
         sec_cnt_r <= '0;
      else if (tick_sec)
         sec_cnt_r <= sec_cnt_r + 1'b1;
   end

   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I || prescale_clr)
         min_cnt_r <= '0;
      else if (tick_hour)
         min_cnt_r <= '0;
      else if (tick_min)
         min_cnt_r <= min_cnt_r + 1'b1;
   end

   always_comb
   begin
      unique case (ctrl_r.timebase_select)
         TB_10MS: step = tick_10ms;
         TB_SEC: step = tick_sec;
         TB_MIN: step = tick_min;
         TB_HOUR: step = tick_hour;
      endcase
   end

   // ****************************************************
   // Running time, held lap value, output
   // ****************************************************
   logic [VAL_W-1:0] running_time_value_r;
   logic [VAL_W-1:0] running_time_value_nxt;
   logic [VAL_W-1:0] held_lap_value_r;
   logic [VAL_W-1:0] elapsed_value_output_r;
   logic wipe;

   assign wipe = in_s.clear | (POWER_LOSS_I & ~ctrl_r.retain);

   always_comb
   begin
      running_time_value_nxt = running_time_value_r;
      if (wipe)
         running_time_value_nxt = '0;
      else if (step)
         running_time_value_nxt = running_time_value_r + 1'b1;
   end

   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I)
         running_time_value_r <= '0;
      else
         running_time_value_r <= running_time_value_nxt;
   end

   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I || wipe)
         held_lap_value_r <= '0;
      else if (lap_rise)
         held_lap_value_r <= running_time_value_r;
   end

   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I || wipe)
         elapsed_value_output_r <= '0;
      else if (in_s.lap)
         elapsed_value_output_r <= lap_rise ? running_time_value_r : held_lap_value_r;
      else
         elapsed_value_output_r <= running_time_value_nxt;
   end

   assign ELAPSED_O = elapsed_value_output_r;

   logic running_r;

   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I)
         running_r <= 1'b0;
      else
         running_r <= run_en;
   end

   assign RUNNING_O = running_r;

   // ****************************************************
   // Register read port
   // ****************************************************
   // Unmapped offsets read as zero so software sees a defined answer.
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;

   always_comb
   begin
      rdata_nxt = '0;
      unique case (ADDR_I)
         CTRL_OFS:
         begin
            rdata_nxt[CTRL_TB_LSB +: 2] = ctrl_r.timebase_select;
            rdata_nxt[CTRL_RETAIN_BIT] = ctrl_r.retain;
         end
         STATUS_OFS:
         begin
            rdata_nxt[STATUS_RUN_BIT] = running_r;
            rdata_nxt[STATUS_LAP_BIT] = lap_prev_r;
            rdata_nxt[STATUS_ENABLE_BIT] = in_s.enable;
            rdata_nxt[STATUS_CLEAR_BIT] = in_s.clear;
         end
         ELAPSED_OFS: rdata_nxt = 32'(elapsed_value_output_r);
         RUNNING_OFS: rdata_nxt = 32'(running_time_value_r);
         HELD_OFS: rdata_nxt = 32'(held_lap_value_r);
         default: rdata_nxt = '0;
      endcase
   end

   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I)
         rdata_r <= '0;
      else if (RD_I)
         rdata_r <= rdata_nxt;
      else
         rdata_r <= '0;
   end

   assign RDATA_O = rdata_r;

   // ****************************************************
   // Assertions and cover points
   // ****************************************************
   default clocking cb @(posedge CLOCK_I);
   endclocking
   default disable iff (RST_I);

   chk_count_advance: assert property (
      step && !wipe |=> running_time_value_r == $past(running_time_value_r) + 1'b1)
      else $error("running time did not advance on a unit tick");

   chk_lap_pause: assert property (
      lap_rise && !in_s.clear && !POWER_LOSS_I |=> $stable(running_time_value_r))
      else $error("running time moved after lap rose");

   chk_lap_resume: assert property (
      lap_fall && in_s.enable && !in_s.clear |-> run_en ##1 running_r)
      else $error("stopwatch did not resume after lap fell");

   chk_clear_zero: assert property (
      in_s.clear |=> elapsed_value_output_r == '0 && running_time_value_r == '0 && held_lap_value_r == '0)
      else $error("clear did not zero the stopwatch");

   chk_unit_gate: assert property (
      !step && !wipe |=> $stable(running_time_value_r))
      else $error("running time moved without a unit tick");

   chk_sec_unit: assert property (
      ctrl_r.timebase_select == TB_SEC && step |-> tick_10ms && csec_cnt_r == 7'(TICKS_PER_SEC - 1))
      else $error("seconds unit not aligned to hundred ticks");

   chk_retain_keep: assert property (
      POWER_LOSS_I && ctrl_r.retain && !in_s.clear && !step |=> $stable(running_time_value_r))
      else $error("retentive count lost across power loss");

   chk_nonretain_wipe: assert property (
      POWER_LOSS_I && !ctrl_r.retain |=> running_time_value_r == '0 && elapsed_value_output_r == '0)
      else $error("non-retentive count survived power loss");

   chk_lap_hold: assert property (
      in_s.lap && lap_prev_r && !wipe |=> $stable(elapsed_value_output_r))
      else $error("output moved while lap held");

   chk_run_output: assert property (
      !in_s.lap && !wipe |=> elapsed_value_output_r == running_time_value_r)
      else $error("output does not show running time");

   chk_lap_capture: assert property (
      lap_rise && !wipe |=> held_lap_value_r == $past(running_time_value_r)
         && elapsed_value_output_r == held_lap_value_r)
      else $error("lap value not captured on lap rise");

   chk_stop_count: assert property (
      !in_s.enable |-> !run_en ##1 !running_r)
      else $error("counting while enable low");

   chk_edge_sample: assert property (
      ##1 lap_prev_r == $past(in_s.lap))
      else $error("lap sample not taken from previous cycle");

   chk_stop_held: assert property (
      !in_s.enable && in_s.lap && lap_prev_r && !wipe |=> elapsed_value_output_r == held_lap_value_r)
      else $error("held lap value not shown while stopped");

   chk_idle_output: assert property (
      !in_s.enable && !in_s.lap && !wipe |=> elapsed_value_output_r == running_time_value_r)
      else $error("output does not show running time while idle");

   cov_run_unit: cover property (run_en && step && ctrl_r.timebase_select == TB_10MS);
   cov_minute_unit: cover property (step && ctrl_r.timebase_select == TB_MIN);
   cov_lap_cycle: cover property (lap_rise ##[1:100] lap_fall);
   cov_clear_while_run: cover property (running_r && in_s.clear);
   cov_retain_loss: cover property (POWER_LOSS_I && ctrl_r.retain && running_time_value_r != '0);

endmodule // elapsed_time_stopwatch

`default_nettype wire

// >>> verification/control_program_model.sv
// Model of the control program that drives enable, lap and clear
`timescale 1ns/1ns
`default_nettype none

module control_program_model
(
   input wire logic clock_i,
   output logic enable_o,
   output logic lap_o,
   output logic clear_o
);
   // ****************************************************
   // Level drivers
   // ****************************************************
   initial
   begin
      enable_o = 1'b0;
      lap_o = 1'b0;
      clear_o = 1'b0;
   end

   // Levels change by non-blocking update right after an edge and stand for the given number of edges
   task automatic drive(input logic en, input logic lap, input logic clr, input int cycles);
      enable_o <= en;
      lap_o <= lap;
      clear_o <= clr;
      repeat (cycles) @(posedge clock_i);
   endtask
endmodule // control_program_model

`default_nettype wire

// >>> verification/test_elapsed_time_stopwatch.sv
// Self-checking testbench of the elapsed-time stopwatch
`timescale 1ns/1ns
`default_nettype none

module test_elapsed_time_stopwatch
   import stopwatch_pkg::*;
;
   // ****************************************************
   // Bench signals
   // ****************************************************
   localparam int TL = 4;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic power_loss = 1'b0;
   logic [ADDR_W-1:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   logic [31:0] elapsed;
   logic running;
   logic enable;
   logic lap;
   logic clear;
   int fail_count = 0;
   int check_count = 0;
   int cycles = 0;

   always #20 clock = ~clock;

   control_program_model ctl_u (.clock_i(clock), .enable_o(enable), .lap_o(lap), .clear_o(clear));

   // Short tick keeps even the minute unit within some tens of thousands of cycles
   elapsed_time_stopwatch #(.TICK_LEN(TL)) dut_u (.CLOCK_I(clock), .RST_I(rst), .ENABLE_I(enable),
      .LAP_I(lap), .CLEAR_I(clear), .POWER_LOSS_I(power_loss), .ADDR_I(addr), .WDATA_I(wdata),
      .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .ELAPSED_O(elapsed), .RUNNING_O(running));

   // ****************************************************
   // Shared tasks
   // ****************************************************
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so they are taken in the middle of it
   task automatic rd_reg(input string what, input logic [7:0] a, input logic [31:0] exp);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      @(negedge clock);
      check(what, rdata, exp);
      @(posedge clock);
   endtask

   // Runs n counted cycles, then stops with enable and lap low
   task automatic run(input int n, input logic [31:0] exp);
      ctl_u.drive(1'b1, 1'b0, 1'b0, n);
      ctl_u.drive(1'b0, 1'b0, 1'b0, 0);
      @(negedge clock);
      check("running", running, 1'b1);
      @(posedge clock);
      @(negedge clock);
      check("running", running, 1'b0);
      check("elapsed", elapsed, exp);
      @(posedge clock);
   endtask

   task automatic power_cycle(input logic [31:0] exp);
      power_loss <= 1'b1;
      @(posedge clock);
      power_loss <= 1'b0;
      @(negedge clock);
      check("retained", elapsed, exp);
      @(posedge clock);
      rd_reg("retained reg", RUNNING_OFS, exp);
   endtask

   // ****************************************************
   // Scenarios
   // ****************************************************
   task automatic t_reset();
      @(negedge clock);
      check("elapsed", elapsed, 32'h0000_0000);
      check("running", running, 1'b0);
      @(posedge clock);
      rd_reg("ctrl", CTRL_OFS, 32'h0000_0000);
      rd_reg("unmapped", 8'h14, 32'h0000_0000);
      $display("test reset done");
   endtask

   task automatic t_lap();
      run(3 * TL, 32'h0000_0003);
      rd_reg("elapsed reg", ELAPSED_OFS, 32'h0000_0003);
      run(TL / 2, 32'h0000_0003);
      ctl_u.drive(1'b1, 1'b1, 1'b0, 20);
      @(negedge clock);
      check("lap hold", elapsed, 32'h0000_0003);
      @(posedge clock);
      rd_reg("paused", RUNNING_OFS, 32'h0000_0003);
      rd_reg("held", HELD_OFS, 32'h0000_0003);
      rd_reg("status", STATUS_OFS, 32'h0000_0006);
      ctl_u.drive(1'b0, 1'b1, 1'b0, 6);
      @(negedge clock);
      check("lap stop", elapsed, 32'h0000_0003);
      @(posedge clock);
      rd_reg("stopped", RUNNING_OFS, 32'h0000_0003);
      run(TL / 2, 32'h0000_0004);
      $display("test lap done");
   endtask

   // Leaves an edge with all levels low so a following drive never lands in the same time step
   task automatic t_clear();
      ctl_u.drive(1'b1, 1'b0, 1'b1, 3);
      @(negedge clock);
      check("clear", elapsed, 32'h0000_0000);
      @(posedge clock);
      rd_reg("running reg", RUNNING_OFS, 32'h0000_0000);
      rd_reg("held reg", HELD_OFS, 32'h0000_0000);
      ctl_u.drive(1'b0, 1'b0, 1'b0, 1);
      $display("test clear done");
   endtask

   task automatic t_timebase();
      wr_reg(CTRL_OFS, 32'h0000_0001);
      rd_reg("ctrl", CTRL_OFS, 32'h0000_0001);
      run(100 * TL - 1, 32'h0000_0000);
      run(1, 32'h0000_0001);
      wr_reg(ELAPSED_OFS, 32'h0000_0005);
      rd_reg("ro elapsed", ELAPSED_OFS, 32'h0000_0001);
      @(negedge clock);
      check("rdata idle", rdata, 32'h0000_0000);
      @(posedge clock);
      // One second is already counted, so 59 more complete the first minute
      wr_reg(CTRL_OFS, 32'h0000_0002);
      rd_reg("ctrl", CTRL_OFS, 32'h0000_0002);
      run(59 * 100 * TL - 1, 32'h0000_0001);
      run(1, 32'h0000_0002);
      wr_reg(CTRL_OFS, 32'h0000_0003);
      rd_reg("ctrl", CTRL_OFS, 32'h0000_0003);
      run(100 * TL, 32'h0000_0002);
      $display("test timebase done");
   endtask

   task automatic t_retain();
      wr_reg(CTRL_OFS, 32'h0000_0000);
      t_clear();
      run(TL, 32'h0000_0001);
      power_cycle(32'h0000_0000);
      wr_reg(CTRL_OFS, 32'h0000_0004);
      run(TL, 32'h0000_0001);
      power_cycle(32'h0000_0001);
      // Reset wipes the count even with retention on
      rst <= 1'b1;
      @(posedge clock);
      rst <= 1'b0;
      @(negedge clock);
      check("reset elapsed", elapsed, 32'h0000_0000);
      @(posedge clock);
      rd_reg("reset ctrl", CTRL_OFS, 32'h0000_0000);
      $display("test retain done");
   endtask

   // A hang is cut short well past the expected run length of about 25000 cycles
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         fail_count++;
         results();
      end
   end

   initial
   begin
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      t_reset();
      t_lap();
      t_clear();
      t_timebase();
      t_retain();
      results();
   end
endmodule // test_elapsed_time_stopwatch

`default_nettype wire
